/* slsc_dev.sv */
// Signed/BCD linear scaling datapath (device end)
//
// Behaviour
// - Condition false: skip, keep result and flags
// - Mode 0 takes 16-bit signed source
// - Mode 0: dY/dX times (source minus intercept)
// - Round quotient to nearest before clamp/write
// - Mode 0: carry marks negative, write magnitude
// - Mode 0: saturate result at plus/minus 9999
// - Mode 0: error on area or setting fault
// - Signed parameters are 16-bit two's complement
// - Zero flag set exactly when result is 0000, except clear after reset
// - Mode 1: dY/dX times source plus intercept
// - Mode 1: carry on entry negates BCD source
// - Mode 1: clamp to upper/lower limit words
// - Mode 1: carry flag left unchanged
// - Mode 1: error on non-BCD source nibble
// - Sequencer gives BCD words, contiguous params
// - Sequencer keeps BCD delta X at 0001..9999
// - Sequencer keeps result out of reserved memory
// - Sequencer sets carry sign before mode 1
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/10ps
module slsc_dev
(
  input  logic    i_core_clk,                        // Core clock, 40 MHz
  input  logic    i_rst_n,                           // Synchronous reset, low
  slsc_if.dev     link,                              // Sequencer side
  output logic    o_busy                             // Operation in progress
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // True when every nibble is a decimal digit
  function automatic logic bcd_ok(input logic [15:0] w);
    return (w[15:12] < 4'ha) && (w[11:8] < 4'ha) &&
           (w[7:4] < 4'ha) && (w[3:0] < 4'ha);
  endfunction

  // Four BCD digits to binary
  function automatic logic [13:0] bcd2bin(input logic [15:0] w);
    return 14'(w[15:12]) * 14'd1000 + 14'(w[11:8]) * 14'd100 +
           14'(w[7:4]) * 14'd10 + 14'(w[3:0]);
  endfunction

  // Binary up to 9999 to four BCD digits (shift and add three)
  function automatic logic [15:0] bin2bcd(input logic [13:0] v);
    logic [29:0] s;
    s = {16'h0000, v};
    for (int i = 0; i < 14; i++)
    begin
      for (int j = 0; j < 4; j++)
      begin
        if (s[14 + 4 * j +: 4] >= 4'h5)
          s[14 + 4 * j +: 4] = s[14 + 4 * j +: 4] + 4'h3;
      end
      s = s << 1;
    end
    return s[29:14];
  endfunction

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  typedef enum logic [3:0]
  {
    ST_IDLE = 4'b0001,                               // Waiting for start
    ST_PREP = 4'b0010,                               // Operand set-up
    ST_DIV  = 4'b0100,                               // Division steps
    ST_FIN  = 4'b1000                                // Round, clamp, write
  } slsc_state_t;

  slsc_state_t          state_r;                     // Sequencer state
  slsc_pkg::slsc_mode_t mode_r;                      // Latched mode
  slsc_pkg::slsc_word_t src_r;                       // Latched source
  slsc_pkg::slsc_word_t par_r [slsc_pkg::NUM_PARAMS];// Latched parameters
  logic                 area_ok_r;                   // Latched area check
  logic                 cy_in_r;                     // Latched entry carry
  logic                 neg_r;                       // Quotient sign
  logic [32:0]          rem_r;                       // Partial remainder
  logic [31:0]          quo_r;                       // Dividend / quotient
  logic [31:0]          den_r;                       // Doubled divisor
  logic [4:0]           step_r;                      // Division step count
  slsc_pkg::slsc_word_t result_r;                    // Result word
  logic                 carry_r;                     // sign_carry_flag
  logic                 zero_r;                      // zero_result_flag
  logic                 error_r;                     // error_flag
  logic                 done_r;                      // Done strobe

  // Operand set-up signals
  logic signed [31:0]   num;                         // Signed numerator
  logic signed [31:0]   den;                         // Signed denominator
  logic [31:0]          num_mag;                     // |numerator|
  logic [31:0]          den_mag;                     // |denominator|
  logic                 op_err;                      // Error found at set-up

  // Result stage signals
  logic signed [33:0]   quot;                        // Signed rounded quotient
  logic signed [33:0]   clamped;                     // Quotient after clamp
  logic [33:0]          mag;                         // |clamped|
  slsc_pkg::slsc_word_t wr_word;                     // Word to be written

  // Division step signals
  logic [32:0]          rem_sh;                      // Remainder shifted in

  // ----------------------------------------------------------------
  // Operand set-up from latched inputs
  // ----------------------------------------------------------------
  always_comb
  begin
    num    = '0;
    den    = '0;
    op_err = 1'b0;
    if (mode_r == slsc_pkg::slsc_signed_to_bcd_scale_op)
    begin
      // Source, intercept and delta X are 16-bit signed
      num = ($signed({{16{src_r[15]}}, src_r}) -
             $signed({{16{par_r[slsc_pkg::P_INTERCEPT][15]}}, par_r[slsc_pkg::P_INTERCEPT]})) *
            $signed({18'h00000, bcd2bin(par_r[slsc_pkg::P_DELTA_Y])});
      den = $signed({{16{par_r[slsc_pkg::P_DELTA_X][15]}}, par_r[slsc_pkg::P_DELTA_X]});
      // Area fault, zero slope base or non-BCD delta Y
      op_err = !area_ok_r || (den == 32'sh0) || !bcd_ok(par_r[slsc_pkg::P_DELTA_Y]);
    end
    else
    begin
      // BCD magnitude, negated when carry was set on entry
      num = $signed({18'h00000, bcd2bin(src_r)});
      if (cy_in_r)
        num = -num;
      num = num * $signed({{16{par_r[slsc_pkg::P_DELTA_Y][15]}}, par_r[slsc_pkg::P_DELTA_Y]});
      // Delta X relies on the sequencer giving BCD 0001..9999
      den = $signed({18'h00000, bcd2bin(par_r[slsc_pkg::P_DELTA_X])});
      op_err = !bcd_ok(src_r);
    end
    num_mag = num[31] ? 32'(-num) : 32'(num);
    den_mag = den[31] ? 32'(-den) : 32'(den);
  end

  // ----------------------------------------------------------------
  // Rounding, clamping and result formatting
  // ----------------------------------------------------------------
  always_comb
  begin
    quot    = neg_r ? -$signed({2'b00, quo_r}) : $signed({2'b00, quo_r});
    clamped = quot;
    mag     = '0;
    wr_word = slsc_pkg::WORD_ZERO;
    if (mode_r == slsc_pkg::slsc_signed_to_bcd_scale_op)
    begin
      // Saturate at plus and minus 9999
      if (quot > $signed({20'h00000, slsc_pkg::BCD_MAX_BIN}))
        clamped = $signed({20'h00000, slsc_pkg::BCD_MAX_BIN});
      else if (quot < -$signed({20'h00000, slsc_pkg::BCD_MAX_BIN}))
        clamped = -$signed({20'h00000, slsc_pkg::BCD_MAX_BIN});
      mag     = clamped[33] ? 34'(-clamped) : 34'(clamped);
      wr_word = bin2bcd(mag[13:0]);
    end
    else
    begin
      // Add the signed intercept to the rounded quotient
      quot    = quot + $signed({{18{par_r[slsc_pkg::P_INTERCEPT][15]}}, par_r[slsc_pkg::P_INTERCEPT]});
      clamped = quot;
      // Clamp to signed limit words, writing the limit crossed
      if (quot > $signed({{18{par_r[slsc_pkg::P_UPPER][15]}}, par_r[slsc_pkg::P_UPPER]}))
        clamped = $signed({{18{par_r[slsc_pkg::P_UPPER][15]}}, par_r[slsc_pkg::P_UPPER]});
      else if (quot < $signed({{18{par_r[slsc_pkg::P_LOWER][15]}}, par_r[slsc_pkg::P_LOWER]}))
        clamped = $signed({{18{par_r[slsc_pkg::P_LOWER][15]}}, par_r[slsc_pkg::P_LOWER]});
      wr_word = clamped[15:0];
    end
  end

  // One restoring division step
  assign rem_sh = {rem_r[31:0], quo_r[31]};

  // ----------------------------------------------------------------
  // Control sequence
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      state_r <= ST_IDLE;
    else
    begin
      unique case (state_r)
        ST_IDLE: if (link.start && link.exec_cond) state_r <= ST_PREP;
        ST_PREP: state_r <= op_err ? ST_IDLE : ST_DIV;
        ST_DIV:  if (step_r == 5'(slsc_pkg::DIV_STEPS - 1)) state_r <= ST_FIN;
        ST_FIN:  state_r <= ST_IDLE;
      endcase
    end
  end

  // Latch operands on the start strobe
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      mode_r    <= slsc_pkg::slsc_signed_to_bcd_scale_op;
      src_r     <= slsc_pkg::WORD_ZERO;
      par_r     <= '{default: slsc_pkg::WORD_ZERO};
      area_ok_r <= 1'b0;
      cy_in_r   <= 1'b0;
    end
    else if (state_r == ST_IDLE && link.start)
    begin
      mode_r    <= link.mode;
      src_r     <= link.source;
      par_r     <= link.param;
      area_ok_r <= link.area_ok;
      cy_in_r   <= link.carry_in;
    end
  end

  // Divider: dividend 2|n|+|d| over 2|d| rounds to nearest
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      rem_r  <= '0;
      quo_r  <= '0;
      den_r  <= '0;
      neg_r  <= 1'b0;
      step_r <= '0;
    end
    else if (state_r == ST_PREP)
    begin
      rem_r  <= '0;
      quo_r  <= 32'({num_mag[30:0], 1'b0} + den_mag);
      den_r  <= {den_mag[30:0], 1'b0};
      neg_r  <= num[31] ^ den[31];
      step_r <= '0;
    end
    else if (state_r == ST_DIV)
    begin
      step_r <= 5'(step_r + 5'd1);
      if (rem_sh >= {1'b0, den_r})
      begin
        rem_r <= 33'(rem_sh - {1'b0, den_r});
        quo_r <= {quo_r[30:0], 1'b1};
      end
      else
      begin
        rem_r <= rem_sh;
        quo_r <= {quo_r[30:0], 1'b0};
      end
    end
  end

  // Result word and flags; untouched when not executed
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      result_r <= slsc_pkg::WORD_ZERO;
      carry_r  <= 1'b0;
      zero_r   <= 1'b0;
      error_r  <= 1'b0;
    end
    else if (state_r == ST_IDLE && link.start && !link.exec_cond)
      carry_r <= link.carry_in;                               // Hand back the carry as it was
    else if (state_r == ST_PREP && op_err)
    begin
      error_r <= 1'b1;
      carry_r <= cy_in_r;                                     // Carry stays as software set it
    end
    else if (state_r == ST_FIN)
    begin
      result_r <= wr_word;
      zero_r   <= (wr_word == slsc_pkg::WORD_ZERO);
      error_r  <= 1'b0;
      // Mode 0 reports sign; mode 1 keeps entry carry
      carry_r  <= (mode_r == slsc_pkg::slsc_signed_to_bcd_scale_op) ? clamped[33] : cy_in_r;
    end
  end

  // Done strobe once result and flags are settled
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      done_r <= 1'b0;
    else
      done_r <= (state_r == ST_IDLE && link.start && !link.exec_cond) ||
                (state_r == ST_PREP && op_err) || (state_r == ST_FIN);
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.done       = done_r;
  assign link.result     = result_r;
  assign link.carry_out  = carry_r;
  assign link.zero_flag  = zero_r;
  assign link.error_flag = error_r;
  assign o_busy          = (state_r != ST_IDLE);

endmodule

/* slsc_pkg.sv */
// Shared constants, types and register map of the signed/BCD linear scaler
package slsc_pkg;

  // ----------------------------------------------------------------
  // Data types
  // ----------------------------------------------------------------
  typedef logic [15:0] slsc_word_t;                  // One operand word

  typedef enum logic
  {
    slsc_signed_to_bcd_scale_op = 1'b0,              // Signed source to BCD
    slsc_bcd_to_signed_scale_op = 1'b1               // BCD source to signed
  } slsc_mode_t;

  // ----------------------------------------------------------------
  // Arithmetic constants
  // ----------------------------------------------------------------
  localparam int          NUM_PARAMS   = 5;          // Parameter words
  localparam int          DIV_STEPS    = 32;         // Divider iterations
  localparam logic [13:0] BCD_MAX_BIN  = 14'h270f;   // 9999
  localparam slsc_word_t  WORD_ZERO    = 16'h0000;   // Reset result word

  // Parameter word positions
  localparam int P_INTERCEPT = 0;                    // Intercept word
  localparam int P_DELTA_X   = 1;                    // Delta X word
  localparam int P_DELTA_Y   = 2;                    // Delta Y word
  localparam int P_UPPER     = 3;                    // Upper limit word
  localparam int P_LOWER     = 4;                    // Lower limit word

  // ----------------------------------------------------------------
  // Controller register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;       // Command bits
  localparam logic [7:0] OFS_SOURCE   = 8'h04;       // Source word
  localparam logic [7:0] OFS_PARAM0   = 8'h08;       // Parameter words 0..4
  localparam logic [7:0] OFS_RESULT   = 8'h1c;       // Result word
  localparam logic [7:0] OFS_STATUS   = 8'h20;       // Busy and flags
  localparam logic [7:0] OFS_INT_STAT = 8'h24;       // Sticky events
  localparam logic [7:0] OFS_INT_MASK = 8'h28;       // Event mask

  // CTRL fields
  localparam int CTRL_START   = 0;                   // Start pulse
  localparam int CTRL_MODE    = 1;                   // Mode select
  localparam int CTRL_EXEC    = 2;                   // Execution condition
  localparam int CTRL_AREA_OK = 3;                   // Params in one area
  localparam int CTRL_SET_CY  = 4;                   // set_carry_op
  localparam int CTRL_CLR_CY  = 5;                   // clear_carry_op

  // STATUS fields
  localparam int STAT_BUSY  = 0;                     // Operation running
  localparam int STAT_CARRY = 1;                     // sign_carry_flag
  localparam int STAT_ZERO  = 2;                     // zero_result_flag
  localparam int STAT_ERROR = 3;                     // error_flag

  // INT_STAT / INT_MASK fields
  localparam int IRQ_DONE  = 0;                      // Operation finished
  localparam int IRQ_ERROR = 1;                      // Finished with error
  localparam logic [1:0] IRQ_RESET = 2'h0;           // Reset value

endpackage

/* slsc_if.sv */
// Interface joining the scaler datapath and its instruction sequencer
`timescale 1ns/10ps
interface slsc_if;
  logic               start;                         // One-cycle start strobe
  logic               exec_cond;                     // Execution condition
  slsc_pkg::slsc_mode_t mode;                        // Operation select
  slsc_pkg::slsc_word_t source;                      // Source word
  slsc_pkg::slsc_word_t param [slsc_pkg::NUM_PARAMS];// Parameter words
  logic               area_ok;                       // Params in one area
  logic               carry_in;                      // sign_carry_flag on entry
  logic               done;                          // One-cycle done strobe
  slsc_pkg::slsc_word_t result;                      // Result word
  logic               carry_out;                     // sign_carry_flag
  logic               zero_flag;                     // zero_result_flag
  logic               error_flag;                    // error_flag

  modport dev (input start, exec_cond, mode, source, param, area_ok, carry_in,
               output done, result, carry_out, zero_flag, error_flag);
  modport seq (output start, exec_cond, mode, source, param, area_ok, carry_in,
               input done, result, carry_out, zero_flag, error_flag);
endinterface

/* slsc_seq.sv */
// Instruction sequencer end: APB register front for the scaler
`timescale 1ns/10ps
module slsc_seq
(
  input  logic        i_core_clk,                    // Core clock, 40 MHz
  input  logic        i_rst_n,                       // Synchronous reset, low
  input  logic        i_psel,                        // APB select
  input  logic        i_penable,                     // APB enable
  input  logic        i_pwrite,                      // APB write
  input  logic [7:0]  i_paddr,                       // APB byte address
  input  logic [31:0] i_pwdata,                      // APB write data
  output logic [31:0] o_prdata,                      // APB read data
  output logic        o_pready,                      // APB ready
  output logic        o_pslverr,                     // APB error
  output logic        o_irq,                         // Level interrupt
  slsc_if.seq         link                           // Datapath side
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic                 start_r;                     // Start strobe
  logic                 busy_r;                      // Waiting for done
  logic                 mode_r;                      // Mode select
  logic                 exec_r;                      // Execution condition
  logic                 area_ok_r;                   // Area check
  logic                 carry_r;                     // sign_carry_flag
  slsc_pkg::slsc_word_t src_r;                       // Source word
  slsc_pkg::slsc_word_t par_r [slsc_pkg::NUM_PARAMS];// Parameter words
  logic [1:0]           int_stat_r;                  // Sticky events
  logic [1:0]           int_mask_r;                  // Event mask
  logic                 wr_en;                       // APB write access
  logic                 rd_en;                       // APB read access
  logic [1:0]           events;                      // Events this cycle

  assign wr_en  = i_psel && i_penable && i_pwrite;
  assign rd_en  = i_psel && i_penable && !i_pwrite;
  assign events = {link.done && link.error_flag, link.done};

  // ----------------------------------------------------------------
  // Command and operand registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      start_r   <= 1'b0;
      mode_r    <= 1'b0;
      exec_r    <= 1'b0;
      area_ok_r <= 1'b0;
      src_r     <= slsc_pkg::WORD_ZERO;
      par_r     <= '{default: slsc_pkg::WORD_ZERO};
    end
    else
    begin
      start_r <= 1'b0;
      if (wr_en && i_paddr == slsc_pkg::OFS_CTRL)
      begin
        // Start only when idle, with operands already loaded
        start_r   <= i_pwdata[slsc_pkg::CTRL_START] && !busy_r;
        mode_r    <= i_pwdata[slsc_pkg::CTRL_MODE];
        exec_r    <= i_pwdata[slsc_pkg::CTRL_EXEC];
        area_ok_r <= i_pwdata[slsc_pkg::CTRL_AREA_OK];
      end
      if (wr_en && i_paddr == slsc_pkg::OFS_SOURCE)
        src_r <= i_pwdata[15:0];
      for (int k = 0; k < slsc_pkg::NUM_PARAMS; k++)
      begin
        if (wr_en && i_paddr == 8'(slsc_pkg::OFS_PARAM0 + 8'(4 * k)))
          par_r[k] <= i_pwdata[15:0];
      end
    end
  end

  // Busy from start until done
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      busy_r <= 1'b0;
    else if (start_r)
      busy_r <= 1'b1;
    else if (link.done)
      busy_r <= 1'b0;
  end

  // Carry: set/clear before mode 1, follows device on done
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      carry_r <= 1'b0;
    else if (link.done)
      carry_r <= link.carry_out;
    else if (wr_en && i_paddr == slsc_pkg::OFS_CTRL && !busy_r)
    begin
      if (i_pwdata[slsc_pkg::CTRL_SET_CY])
        carry_r <= 1'b1;
      else if (i_pwdata[slsc_pkg::CTRL_CLR_CY])
        carry_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status (read clears, new event wins) and mask
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      int_stat_r <= slsc_pkg::IRQ_RESET;
      int_mask_r <= slsc_pkg::IRQ_RESET;
    end
    else
    begin
      int_stat_r <= ((rd_en && i_paddr == slsc_pkg::OFS_INT_STAT) ? 2'b00 : int_stat_r) | events;
      if (wr_en && i_paddr == slsc_pkg::OFS_INT_MASK)
        int_mask_r <= i_pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Read mux; unmapped addresses read zero
  // ----------------------------------------------------------------
  always_comb
  begin
    o_prdata = 32'h0000_0000;
    if (i_paddr == slsc_pkg::OFS_CTRL)
      o_prdata = {28'h0000000, area_ok_r, exec_r, mode_r, 1'b0};
    else if (i_paddr == slsc_pkg::OFS_SOURCE)
      o_prdata = {16'h0000, src_r};
    else if (i_paddr == slsc_pkg::OFS_RESULT)
      o_prdata = {16'h0000, link.result};
    else if (i_paddr == slsc_pkg::OFS_STATUS)
      o_prdata = {28'h0000000, link.error_flag, link.zero_flag, carry_r, busy_r};
    else if (i_paddr == slsc_pkg::OFS_INT_STAT)
      o_prdata = {30'h00000000, int_stat_r};
    else if (i_paddr == slsc_pkg::OFS_INT_MASK)
      o_prdata = {30'h00000000, int_mask_r};
    for (int k = 0; k < slsc_pkg::NUM_PARAMS; k++)
    begin
      if (i_paddr == 8'(slsc_pkg::OFS_PARAM0 + 8'(4 * k)))
        o_prdata = {16'h0000, par_r[k]};
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_pready       = 1'b1;
  assign o_pslverr      = 1'b0;
  assign o_irq          = |(int_stat_r & int_mask_r);
  assign link.start     = start_r;
  assign link.exec_cond = exec_r;
  assign link.mode      = slsc_pkg::slsc_mode_t'(mode_r);
  assign link.source    = src_r;
  assign link.param     = par_r;
  assign link.area_ok   = area_ok_r;
  assign link.carry_in  = carry_r;

endmodule

/* slsc_monitor.sv */
// Link checker of the signed/BCD linear scaler
`timescale 1ns/10ps
module slsc_monitor
(
  input wire logic                 i_core_clk, // Clock
  input wire logic                 i_rst_n,    // Reset, low
  input wire logic                 start,      // Start strobe
  input wire logic                 exec_cond,  // Condition
  input wire slsc_pkg::slsc_mode_t mode,       // Mode
  input wire slsc_pkg::slsc_word_t source,     // Source
  input wire logic                 area_ok,    // Area good
  input wire logic                 carry_in,   // Carry in
  input wire logic                 done,       // Done strobe
  input wire slsc_pkg::slsc_word_t result,     // Result
  input wire logic                 carry_out,  // Carry
  input wire logic                 zero_flag,  // Zero
  input wire logic                 error_flag  // Error
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  wire m0  = exec_cond & (mode == slsc_pkg::slsc_signed_to_bcd_scale_op); // Mode 0 run
  wire m1  = exec_cond & (mode == slsc_pkg::slsc_bcd_to_signed_scale_op); // Mode 1 run
  wire bad = (source[3:0] > 9) | (source[7:4] > 9) | (source[11:8] > 9) | (source[15:12] > 9); // Non-BCD
  AST_SKIP: assert property (start & !exec_cond |=> done & $stable(result) & $stable(error_flag)) else $error("skip");
  AST_PULSE: assert property (done |=> !done) else $error("done width");
  AST_ZERO: assert property (done & !error_flag |-> zero_flag == (result == 16'h0)) else $error("zero");
  AST_BCD: assert property (done & m0 & !error_flag |-> result[15:12] < 10 && result[11:8] < 10 && result[7:4] < 10 && result[3:0] < 10) else $error("bcd");
  AST_CY0: assert property (done & m0 & !error_flag & result == 16'h0 |-> !carry_out) else $error("carry");
  AST_AREA: assert property (start & m0 & !area_ok |-> ##2 done & error_flag) else $error("area");
  AST_M1CY: assert property (start & m1 |-> ##[1:40] done ##0 carry_out == carry_in) else $error("m1 carry");
  AST_M1ER: assert property (start & m1 & bad |-> ##2 done & error_flag) else $error("m1 error");
endmodule

/* slsc_tb_top.sv */
// Testbench of the scaler: sequencer and datapath back to back
`timescale 1ns/10ps
module slsc_tb_top;
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0; // Bus and clock
  logic [7:0]  paddr = 0;                                     // Address
  logic [31:0] pwdata = 0, prdata, q;                          // Data
  logic        pready, pslverr, irq, busy;                     // Status
  int          error_cnt = 0, n_tests = 0;                     // Counters
  slsc_if lk();
  slsc_dev i_slsc_dev (.i_core_clk(clk), .i_rst_n(rst_n), .link(lk.dev), .o_busy(busy));
  slsc_seq i_slsc_seq (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_irq(irq), .link(lk.seq));
  slsc_monitor i_slsc_monitor (.i_core_clk(clk), .i_rst_n(rst_n), .start(lk.start), .exec_cond(lk.exec_cond),
    .mode(lk.mode), .source(lk.source), .area_ok(lk.area_ok), .carry_in(lk.carry_in), .done(lk.done),
    .result(lk.result), .carry_out(lk.carry_out), .zero_flag(lk.zero_flag), .error_flag(lk.error_flag));
  always #12.5 clk = ~clk;
  // Compare and count
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // One APB transfer, read data kept in q
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    q = prdata;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  // Load, run one operation, compare result and status
  task op(input logic [5:0] c, input logic [15:0] s, input logic [15:0] p [5], input logic [15:0] r, st);
    apb(1'h1, 8'h04, {16'h0, s});
    for (int i = 0; i < 5; i++) apb(1'h1, 8'h08 + 8'(4 * i), {16'h0, p[i]});
    apb(1'h1, 8'h00, {26'h0, c});
    apb(1'h1, 8'h00, {28'h0, c[3:1], 1'h1});
    for (int i = 0; i < 80 && lk.done !== 1'h1; i++) @(posedge clk);
    chk({29'h0, pslverr, busy, lk.done}, 32'h1);
    apb(1'h0, 8'h1c, 32'h0);
    chk(q, {16'h0, r});
    apb(1'h0, 8'h20, 32'h0);
    chk(q, {16'h0, st});
    $display("Test done, source %h", s);
  endtask
  // Count line, verdict and end of run
  task stop_test;
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog against a hang
  initial
  begin
    #(25 * 20000);
    error_cnt++;
    stop_test;
  end
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    apb(1'h1, 8'h28, 32'h3);
    op(6'h2c, 16'hffe2, '{16'h0, 16'h5, 16'h3, 16'h0, 16'h0}, 16'h0018, 16'h2);
    op(6'h2c, 16'h0007, '{16'h0, 16'h2, 16'h1, 16'h0, 16'h0}, 16'h0004, 16'h0);
    op(6'h2c, 16'h7fff, '{16'h0, 16'h1, 16'h9999, 16'h0, 16'h0}, 16'h9999, 16'h0);
    op(6'h2c, 16'h8000, '{16'h0, 16'h1, 16'h9999, 16'h0, 16'h0}, 16'h9999, 16'h2);
    op(6'h2c, 16'h0005, '{16'h5, 16'h1, 16'h1, 16'h0, 16'h0}, 16'h0000, 16'h4);
    op(6'h24, 16'h0005, '{16'h5, 16'h1, 16'h1, 16'h0, 16'h0}, 16'h0000, 16'hc);
    op(6'h28, 16'h0009, '{16'h0, 16'h1, 16'h1, 16'h0, 16'h0}, 16'h0000, 16'hc);
    op(6'h1e, 16'h0010, '{16'h5, 16'h2, 16'h3, 16'h7ff, 16'hf800}, 16'hfff6, 16'h2);
    op(6'h2e, 16'h9999, '{16'h0, 16'h1, 16'h7fff, 16'h7ff, 16'hf800}, 16'h07ff, 16'h0);
    op(6'h1e, 16'h9999, '{16'h0, 16'h1, 16'h7fff, 16'h7ff, 16'hf800}, 16'hf800, 16'h2);
    op(6'h2e, 16'h00a0, '{16'h0, 16'h1, 16'h1, 16'h7ff, 16'hf800}, 16'hf800, 16'h8);
    chk({31'h0, irq}, 32'h1);
    apb(1'h0, 8'h24, 32'h0);
    chk(q, 32'h3);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    stop_test;
  end
endmodule
